// ===== core/sfrfe_pkg.sv
// Purpose: Shared constants and types of the serial flash array read front end.
// Assumes: Header is opcode byte plus three address bytes, msb first.
// Notes:   Bit counts are in serial clock edges from select falling.
package sfrfe_pkg;

    // Header layout
    localparam int CMD_W  = 32;
    localparam int OPC_W  = 8;
    localparam int ADDR_W = 24;
    localparam int BYTE_W = 8;

    // Array geometry
    localparam int PAGE_W = 13;
    localparam int OFF_W  = 10;
    localparam int ARR_W  = PAGE_W + OFF_W;

    // Page field position inside the address field, per page mode
    localparam int A528_PAGE_LSB = 10;
    localparam int A512_PAGE_LSB = 9;

    // Last byte offset of a page
    localparam logic [OFF_W-1:0] LAST_528 = 10'h20F;
    localparam logic [OFF_W-1:0] LAST_512 = 10'h1FF;

    // Opcodes
    localparam logic [OPC_W-1:0] OPC_LEGACY = 8'hE8;
    localparam logic [OPC_W-1:0] OPC_FAST   = 8'h0B;

    // Serial bit counter marks
    localparam int                CNT_W            = 7;
    localparam logic [CNT_W-1:0]  CNT_HDR          = 7'h20;
    localparam logic [CNT_W-1:0]  CNT_HDR_LAST     = 7'h1F;
    localparam logic [CNT_W-1:0]  CNT_START_FAST   = 7'h28;
    localparam logic [CNT_W-1:0]  CNT_START_LEGACY = 7'h40;
    localparam logic [2:0]        OUT_LAST         = 3'h7;

    // Self-timed operation reported by the program/erase engine
    typedef enum logic [2:0] {
        BUSY_NONE,
        BUSY_PROGRAM,
        BUSY_ERASE_PAGE,
        BUSY_ERASE_BLOCK,
        BUSY_ERASE_SECTOR,
        BUSY_ERASE_CHIP,
        BUSY_COMPARE,
        BUSY_TRANSFER
    } sfrfe_busy_t;

    // Control sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQ,
        ST_WAIT,
        ST_SEND,
        ST_HALT
    } sfrfe_state_t;

endpackage

// ===== core/sfrfe_addr_if.sv
// Purpose: Carries load, step and current address between sequencer and counter.
// Assumes: Both ends run on the system clock.
// Notes:   Word is the raw 24-bit address field.
`timescale 1ns/1ps
interface sfrfe_addr_if;
    import sfrfe_pkg::*;

    logic              load;
    logic              step;
    logic              page_512;
    logic [ADDR_W-1:0] word;
    logic [PAGE_W-1:0] page_number;
    logic [OFF_W-1:0]  page_byte_offset;

    modport ctl (output load, output step, output page_512, output word,
                 input page_number, input page_byte_offset);
    modport ctr (input load, input step, input page_512, input word,
                 output page_number, output page_byte_offset);
endinterface

// ===== core/sfrfe_sync.sv
// Purpose: Two flip-flop synchroniser for levels and toggles.
// Assumes: Input changes slowly relative to the destination clock.
// Notes:   Reset is asynchronous so it also serves the link domain.
`timescale 1ns/1ps
module sfrfe_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // First stage feeds only the second
    always_comb begin
        meta_next = i_d;
        q_next    = meta_reg;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign o_q = q_reg;
endmodule

// ===== core/sfrfe_addr_ctr.sv
// Purpose: Main-array address counter with page crossover and array wrap.
// Assumes: Load and step never come in the same cycle.
// Notes:   Offsets beyond the last byte of a page also cross to the next page.
`timescale 1ns/1ps
module sfrfe_addr_ctr
    import sfrfe_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Control
    sfrfe_addr_if.ctr ctr
);
    logic [PAGE_W-1:0] page_reg;
    logic [PAGE_W-1:0] page_next;
    logic [OFF_W-1:0]  off_reg;
    logic [OFF_W-1:0]  off_next;
    logic [OFF_W-1:0]  last_off;

    // Load splits the field per mode; step walks byte by byte
    always_comb begin
        page_next = page_reg;
        off_next  = off_reg;
        last_off  = ctr.page_512 ? LAST_512 : LAST_528;
        if (ctr.load) begin
            if (ctr.page_512) begin
                page_next = ctr.word[A512_PAGE_LSB +: PAGE_W];
                off_next  = OFF_W'(ctr.word[A512_PAGE_LSB-1:0]);
            end else begin
                page_next = ctr.word[A528_PAGE_LSB +: PAGE_W];
                off_next  = ctr.word[A528_PAGE_LSB-1:0];
            end
        end else if (ctr.step) begin
            if (off_reg >= last_off) begin
                off_next  = '0;
                page_next = page_reg + PAGE_W'(1);
            end else begin
                off_next = off_reg + OFF_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            page_reg <= '0;
            off_reg  <= '0;
        end else begin
            page_reg <= page_next;
            off_reg  <= off_next;
        end
    end

    assign ctr.page_number      = page_reg;
    assign ctr.page_byte_offset = off_reg;
endmodule

// ===== core/sfrfe_top.sv
// Purpose: Serial front end that decodes continuous array reads and streams array data.
// Assumes: Array answers a read request with one valid pulse; engine reports busy kind.
// Notes:   Serial logic runs on the serial clock and is cleared by select high.
`timescale 1ns/1ps

// Summary of operation
// - Reset pin low aborts, returns to idle
// - Held in reset while pin stays low
// - Internal power-on reset, pin unconstrained
// - Ready/busy pulls low during self-timed work
// - Busy refuses array access, other buffer free
// - Page programming; four erase granularities
// - Select falls, then opcode and address
// - Everything shifted most significant bit first
// - 528 mode: 13 page, 10 offset bits
// - 512 mode: 22-bit linear, 13 page bits
// - E8 read: address, four ignored bytes
// - 0B read: address, one dummy byte
// - Address counter advances during streaming
// - Page end continues at next page
// - Array end wraps to first page
// - Select rising ends read, output released
// - Reads bypass both buffers, untouched
// - Sample rising edge, drive falling edge
// - Deselected: input ignored, output released
module sfrfe_top
    import sfrfe_pkg::*;
(
    // System clock and power-on reset
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // Device pins
    input  wire logic              i_pin_reset_n,
    input  wire logic              i_cs_n,
    input  wire logic              i_sck,
    input  wire logic              i_si,
    output logic                   o_so,
    output logic                   o_so_oe,
    output logic                   o_rdy_busy,
    output logic                   o_rdy_busy_oe,
    // Configuration and engine status
    input  wire logic              i_page_512,
    input  wire sfrfe_busy_t       i_busy_kind,
    // Main array read port
    output logic                   o_arr_rd_req,
    output logic [ARR_W-1:0]       o_arr_rd_addr,
    input  wire logic              i_arr_rd_valid,
    input  wire logic [BYTE_W-1:0] i_arr_rd_data
);
    // ---------------- Serial clock domain ----------------
    logic [CNT_W-1:0]  bit_cnt_reg;
    logic [CNT_W-1:0]  bit_cnt_next;
    logic [CMD_W-1:0]  shift_reg;
    logic [CMD_W-1:0]  shift_next;
    logic [CMD_W-1:0]  cmd_word_reg;
    logic [CMD_W-1:0]  cmd_word_next;
    logic              cmd_rdy_reg;
    logic              cmd_rdy_next;
    logic [BYTE_W-1:0] hold_reg;
    logic [BYTE_W-1:0] hold_next;
    logic              fill_tgl_reg;
    logic              fill_tgl_next;
    logic              ack_tgl_reg;
    logic              ack_tgl_next;
    logic [CNT_W-1:0]  start_cnt;
    logic              data_phase;
    logic              hold_full;
    logic              dtgl_s;

    // Falling-edge output group
    logic              so_reg;
    logic              so_next;
    logic              so_en_reg;
    logic              so_en_next;
    logic [BYTE_W-2:0] out_shift_reg;
    logic [BYTE_W-2:0] out_shift_next;
    logic [2:0]        out_cnt_reg;
    logic [2:0]        out_cnt_next;
    logic              consume_tgl_reg;
    logic              consume_tgl_next;

    // ---------------- System clock domain ----------------
    sfrfe_state_t      state_reg;
    sfrfe_state_t      state_next;
    logic [BYTE_W-1:0] data_reg;
    logic [BYTE_W-1:0] data_next;
    logic              dtgl_reg;
    logic              dtgl_next;
    logic              busy_reg;
    logic              busy_next;
    logic              sel_s;
    logic              pin_rst_s;
    logic              ack_s;
    logic              cmd_rdy_s;
    logic [OPC_W-1:0]  opcode;
    logic              stream_live;

    sfrfe_addr_if addr_if ();

    // Data byte toggle from the system side
    sfrfe_sync #(
        .W (1)
    ) u_sync_sck (
        .i_clk (i_sck),
        .i_rst (i_cs_n),
        .i_d   (dtgl_reg),
        .o_q   (dtgl_s)
    );

    // Select, reset pin, ack and header-ready into the system side
    sfrfe_sync #(
        .W (4)
    ) u_sync_sys (
        .i_clk (i_clk),
        .i_rst (i_reset),
        .i_d   ({~i_cs_n, ~i_pin_reset_n, ack_tgl_reg, cmd_rdy_reg}),
        .o_q   ({sel_s, pin_rst_s, ack_s, cmd_rdy_s})
    );

    sfrfe_addr_ctr u_addr_ctr (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .ctr     (addr_if)
    );

    assign start_cnt  = (cmd_word_reg[CMD_W-1 -: OPC_W] == OPC_FAST) ? CNT_START_FAST : CNT_START_LEGACY;
    assign data_phase = (bit_cnt_reg == start_cnt);
    assign hold_full  = (fill_tgl_reg != consume_tgl_reg);

    // Header shifting and hand-off of array bytes into the hold slot
    always_comb begin
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        cmd_word_next = cmd_word_reg;
        cmd_rdy_next  = cmd_rdy_reg;
        hold_next     = hold_reg;
        fill_tgl_next = fill_tgl_reg;
        ack_tgl_next  = ack_tgl_reg;
        if (bit_cnt_reg < CNT_HDR) begin
            shift_next   = {shift_reg[CMD_W-2:0], i_si};
            bit_cnt_next = bit_cnt_reg + CNT_W'(1);
            if (bit_cnt_reg == CNT_HDR_LAST) begin
                cmd_word_next = {shift_reg[CMD_W-2:0], i_si};
                cmd_rdy_next  = 1'b1; // One header per frame
            end
        end else if (!data_phase) begin
            // Ignored bytes only advance the count
            bit_cnt_next = bit_cnt_reg + CNT_W'(1);
        end
        // Data word is stable while the toggles differ
        if ((dtgl_s != ack_tgl_reg) && !hold_full) begin
            hold_next     = data_reg;
            fill_tgl_next = ~fill_tgl_reg;
            ack_tgl_next  = ~ack_tgl_reg;
        end
    end

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt_reg  <= '0;
            shift_reg    <= '0;
            cmd_word_reg <= '0;
            cmd_rdy_reg  <= 1'b0;
            hold_reg     <= '0;
            fill_tgl_reg <= 1'b0;
            ack_tgl_reg  <= 1'b0;
        end else begin
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            cmd_word_reg <= cmd_word_next;
            cmd_rdy_reg  <= cmd_rdy_next;
            hold_reg     <= hold_next;
            fill_tgl_reg <= fill_tgl_next;
            ack_tgl_reg  <= ack_tgl_next;
        end
    end

    // Output shifter; an empty hold slot at a byte start stops driving
    always_comb begin
        so_next          = so_reg;
        so_en_next       = so_en_reg;
        out_shift_next   = out_shift_reg;
        out_cnt_next     = out_cnt_reg;
        consume_tgl_next = consume_tgl_reg;
        if (data_phase) begin
            if (out_cnt_reg == '0) begin
                if (hold_full) begin
                    so_next          = hold_reg[BYTE_W-1];
                    out_shift_next   = hold_reg[BYTE_W-2:0];
                    out_cnt_next     = OUT_LAST;
                    consume_tgl_next = ~consume_tgl_reg;
                    so_en_next       = 1'b1;
                end else begin
                    so_en_next = 1'b0; // Refused or underrun
                end
            end else begin
                so_next        = out_shift_reg[BYTE_W-2];
                out_shift_next = {out_shift_reg[BYTE_W-3:0], 1'b0};
                out_cnt_next   = out_cnt_reg - 3'h1;
            end
        end
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            so_reg          <= 1'b0;
            so_en_reg       <= 1'b0;
            out_shift_reg   <= '0;
            out_cnt_reg     <= '0;
            consume_tgl_reg <= 1'b0;
        end else begin
            so_reg          <= so_next;
            so_en_reg       <= so_en_next;
            out_shift_reg   <= out_shift_next;
            out_cnt_reg     <= out_cnt_next;
            consume_tgl_reg <= consume_tgl_next;
        end
    end

    // ---------------- Command sequencer ----------------
    assign opcode = cmd_word_reg[CMD_W-1 -: OPC_W];

    // Fetch one byte ahead so the stream never waits on the array
    always_comb begin
        state_next       = state_reg;
        data_next        = data_reg;
        dtgl_next        = dtgl_reg;
        busy_next        = (i_busy_kind != BUSY_NONE);
        addr_if.load     = 1'b0;
        addr_if.step     = 1'b0;
        addr_if.word     = cmd_word_reg[ADDR_W-1:0];
        addr_if.page_512 = i_page_512;
        if (pin_rst_s || !sel_s) begin
            state_next = ST_IDLE;
            dtgl_next  = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (cmd_rdy_s) begin
                        if (((opcode == OPC_LEGACY) || (opcode == OPC_FAST)) && !busy_reg) begin
                            addr_if.load = 1'b1;
                            state_next   = ST_REQ;
                        end else begin
                            state_next = ST_HALT;
                        end
                    end
                end
                ST_REQ: begin
                    state_next = ST_WAIT;
                end
                ST_WAIT: begin
                    if (i_arr_rd_valid) begin
                        data_next    = i_arr_rd_data;
                        dtgl_next    = ~dtgl_reg;
                        addr_if.step = 1'b1;
                        state_next   = ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (ack_s == dtgl_reg) begin
                        state_next = ST_REQ;
                    end
                end
                ST_HALT: begin
                    state_next = ST_HALT; // Wait for deselect
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            data_reg  <= '0;
            dtgl_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            data_reg  <= data_next;
            dtgl_reg  <= dtgl_next;
            busy_reg  <= busy_next;
        end
    end

    // Array port driven from the state and counter flops
    assign o_arr_rd_req  = (state_reg == ST_REQ);
    assign o_arr_rd_addr = {addr_if.page_number, addr_if.page_byte_offset};

    // Output only while a granted read is live; pin reset cuts it within three system clocks, via the synchroniser
    assign stream_live = (state_reg != ST_IDLE) && (state_reg != ST_HALT);

    assign o_so_oe = so_en_reg & ~i_cs_n & stream_live;
    assign o_so    = so_reg;

    assign o_rdy_busy    = 1'b0;
    assign o_rdy_busy_oe = busy_reg;
endmodule

// ===== dv/sfrfe_monitor.sv
// Purpose: Concurrent checks on the front end pins and array read port.
// Assumes: The array raises valid only to answer a pending request.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module sfrfe_monitor
    import sfrfe_pkg::*;
(
    // Clock and reset
    input wire logic             i_clk,
    input wire logic             i_reset,
    // Device pins
    input wire logic             i_pin_reset_n,
    input wire logic             i_cs_n,
    input wire logic             o_so_oe,
    input wire logic             o_rdy_busy,
    input wire logic             o_rdy_busy_oe,
    input wire sfrfe_busy_t      i_busy_kind,
    // Array port
    input wire logic             o_arr_rd_req,
    input wire logic [ARR_W-1:0] o_arr_rd_addr,
    input wire logic             i_arr_rd_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Request followed by a cycle with no answer yet
    sequence s_req_wait;
        o_arr_rd_req ##1 !i_arr_rd_valid;
    endsequence

    // Answer taken while the frame is still live
    sequence s_answer;
        i_arr_rd_valid && !i_cs_n && i_pin_reset_n;
    endsequence

    AST_DESELECT_RELEASE: assert property (i_cs_n |-> !o_so_oe)
        else $error("SO driven while deselected");
    AST_RDY_LOW_LEVEL: assert property (o_rdy_busy == 1'b0)
        else $error("Ready busy pin drives high");
    AST_BUSY_PULLS: assert property (i_busy_kind != BUSY_NONE |=> o_rdy_busy_oe)
        else $error("Ready busy not pulled during busy");
    AST_BUSY_RELEASES: assert property (i_busy_kind == BUSY_NONE |=> !o_rdy_busy_oe)
        else $error("Ready busy pulled while idle");
    AST_PIN_ABORT: assert property ($fell(i_pin_reset_n) |-> ##[0:4] !o_so_oe)
        else $error("Stream not aborted by reset pin");
    AST_PIN_HELD: assert property (!i_pin_reset_n [*5] |-> !o_so_oe && !o_arr_rd_req)
        else $error("Activity while reset pin low");
    AST_REQ_PULSE: assert property (o_arr_rd_req |=> !o_arr_rd_req)
        else $error("Array requests back to back");
    AST_ADDR_HOLD: assert property (s_req_wait |-> $stable(o_arr_rd_addr))
        else $error("Array address moved before answer");
    AST_ADDR_STEP: assert property (s_answer |=> o_arr_rd_addr != $past(o_arr_rd_addr))
        else $error("Array address did not advance");
endmodule

bind sfrfe_top sfrfe_monitor sfrfe_monitor_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin_reset_n(i_pin_reset_n), .i_cs_n(i_cs_n),
    .o_so_oe(o_so_oe), .o_rdy_busy(o_rdy_busy), .o_rdy_busy_oe(o_rdy_busy_oe),
    .i_busy_kind(i_busy_kind), .o_arr_rd_req(o_arr_rd_req), .o_arr_rd_addr(o_arr_rd_addr),
    .i_arr_rd_valid(i_arr_rd_valid)
);

// ===== dv/sfrfe_host_model.sv
// Purpose: Host side of the serial link: frames commands and reads the stream.
// Assumes: Mode 0 clocking, 30 ns serial clock only inside frames.
// Notes:   Ignored phases carry a toggling pattern, never a held value.
`timescale 1ns/1ps
module sfrfe_host_model (
    // Serial pins toward the device
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    // Device answer
    input  wire logic i_so,
    input  wire logic i_so_oe
);
    logic [7:0] rx_q[$];
    int         oe_ones;

    // Idle link: deselected, clock parked low
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end

    // One frame: header, nd ignored bytes, nb bytes read back
    task automatic frame(input logic [7:0] opc, input logic [23:0] addr, input int nd, input int nb);
        logic [31:0] hdr;
        logic [7:0]  cur;
        hdr     = {opc, addr};
        cur     = 8'h00;
        oe_ones = 0;
        rx_q.delete();
        // select held low for whole frame
        o_cs_n <= 1'b0;
        #15;
        for (int k = 0; k < 32 + 8 * (nd + nb); k++) begin
            o_si <= (k < 32) ? hdr[31-k] : ~o_si;
            #15;
            o_sck <= 1'b1;
            if (k >= 32 + 8 * nd) begin
                // Released output reads as the inverse so a dropped enable corrupts data
                cur = {cur[6:0], (i_so_oe === 1'b1) ? i_so : ~i_so};
                oe_ones += (i_so_oe === 1'b1) ? 1 : 0;
                if ((k - 32) % 8 == 7)
                    rx_q.push_back(cur);
            end
            #15;
            o_sck <= 1'b0;
        end
        #15;
        o_cs_n <= 1'b1;
        o_si   <= ~o_si;
        #60; // Gap lets the system side settle
    endtask
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench for continuous array reads and pin behaviour.
// Assumes: Array content is a fixed function of page and offset.
// Notes:   Expected streams come from an integer model of the address rules.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    import sfrfe_pkg::*;
    logic              clk, reset, pin_reset_n, cs_n, sck, si, so, so_oe;
    logic              rdy_busy, rdy_busy_oe, page_512, rd_req, rd_valid;
    logic [ARR_W-1:0]  rd_addr;
    logic [BYTE_W-1:0] rd_data;
    sfrfe_busy_t       busy_kind;
    int                failures, comparisons, lat;
    logic [7:0]        exp_q[$];

    initial clk = 1'b0;
    always #2 clk = ~clk;

    sfrfe_top sfrfe_top_inst (
        .i_clk(clk), .i_reset(reset), .i_pin_reset_n(pin_reset_n), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_rdy_busy(rdy_busy),
        .o_rdy_busy_oe(rdy_busy_oe), .i_page_512(page_512), .i_busy_kind(busy_kind),
        .o_arr_rd_req(rd_req), .o_arr_rd_addr(rd_addr), .i_arr_rd_valid(rd_valid),
        .i_arr_rd_data(rd_data));
    sfrfe_host_model sfrfe_host_model_inst (
        .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so), .i_so_oe(so_oe));

    // Array answers each request after one to four cycles; each signal set once per edge
    always @(posedge clk) begin
        if (reset) begin
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
            lat      <= 0;
        end else begin
            rd_valid <= (rd_req !== 1'b1) && (lat == 1);
            if (rd_req === 1'b1) begin
                lat <= 1 + $urandom_range(3);
            end else if (lat > 0) begin
                lat <= lat - 1;
            end
            if (lat == 1) begin
                rd_data <= 8'(rd_addr[9:0] + rd_addr[22:10] * 13'h5);
            end
        end
    end

    task automatic end_sim();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One read frame, checked against the model when it should be served
    task automatic run(input logic [7:0] opc, input logic [23:0] a, input logic m512, input int nb,
                       input logic ok);
        int pg, off, last;
        @(posedge clk) page_512 <= m512;
        pg   = m512 ? (a >> 9) & 8191 : (a >> 10) & 8191;
        off  = m512 ? a & 511 : a & 1023;
        last = m512 ? 511 : 527;
        exp_q.delete();
        for (int i = 0; i < nb; i++) begin
            exp_q.push_back(8'(off + pg * 5));
            if (off >= last) begin
                off = 0;
                pg  = (pg + 1) % 8192;
            end else begin
                off++;
            end
        end
        sfrfe_host_model_inst.frame(opc, a, (opc == OPC_LEGACY) ? 4 : 1, nb);
        `CHK("so_oe bits", ok ? 8 * nb : 0, sfrfe_host_model_inst.oe_ones)
        if (ok)
            foreach (exp_q[i])
                `CHK("stream byte", exp_q[i], sfrfe_host_model_inst.rx_q[i])
        @(posedge clk);
        `CHK("so_oe deselected", 1'b0, so_oe)
    endtask

    initial begin
        reset       = 1'b1;
        pin_reset_n = 1'b1; // reset pin held high until the mid-stream abort
        page_512    = 1'b0;
        busy_kind   = BUSY_NONE;
        failures    = 0;
        comparisons = 0;
        void'($urandom(42));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (5) @(posedge clk);
        run(OPC_FAST, 24'h00160E, 1'b0, 4, 1'b1);
        run(OPC_LEGACY, 24'hFFFFFE, 1'b1, 4, 1'b1);
        run(OPC_LEGACY, 24'h7FFFFF, 1'b0, 3, 1'b1);
        for (int i = 0; i < 4; i++)
            run(i[0] ? OPC_FAST : OPC_LEGACY, 24'($urandom), 1'($urandom), 3, 1'b1);
        run(8'h03, 24'h000000, 1'b0, 2, 1'b0);
        // Every self-timed kind pulls the ready line
        for (int k = 1; k < 8; k++) begin
            @(posedge clk) busy_kind <= sfrfe_busy_t'(k);
            repeat (2) @(posedge clk);
            #1;
            `CHK("busy pull", 1'b1, rdy_busy_oe)
            `CHK("busy level", 1'b0, rdy_busy)
        end
        run(OPC_FAST, 24'h000100, 1'b0, 2, 1'b0);
        @(posedge clk) busy_kind <= BUSY_NONE;
        repeat (2) @(posedge clk);
        #1;
        `CHK("busy release", 1'b0, rdy_busy_oe)
        // Reset pin dropped in mid-stream
        fork
            sfrfe_host_model_inst.frame(OPC_FAST, 24'h000000, 1, 6);
            begin
                repeat (400) @(posedge clk);
                pin_reset_n <= 1'b0;
            end
        join
        `CHK("stream cut", 1'b1, sfrfe_host_model_inst.oe_ones inside {[1:47]})
        run(OPC_FAST, 24'h000000, 1'b0, 2, 1'b0);
        @(posedge clk) pin_reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        run(OPC_FAST, 24'h000208, 1'b0, 2, 1'b1);
        end_sim();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule
